// >>> inc/srbp_pkg.sv
// shared constants, state types and decoding for the serial receive path
package srbp_pkg;
    localparam int          DIV_W       = 12;
    localparam int          ENTRY_W     = 12;
    localparam int          ENT_NINTH   = 11;
    localparam int          ENT_FE      = 10;
    localparam int          ENT_DOR     = 9;
    localparam int          ENT_PE      = 8;
    localparam int          FIFO_DEPTH  = 2;
    localparam logic [4:0]  OS_NORMAL   = 5'h10;
    localparam logic [4:0]  OS_DOUBLE   = 5'h08;
    localparam logic [2:0]  SIZE_NINE   = 3'h7;
    localparam logic [1:0]  PAR_EVEN    = 2'h2;
    localparam logic [1:0]  PAR_ODD     = 2'h3;
    localparam logic [3:0]  SPI_LAST_PH = 4'hf;
    localparam logic        LINE_IDLE   = 1'b1;
    localparam logic [DIV_W-1:0] DIV_RST = 12'h000;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b011,
        RX_PAR   = 3'b010,
        RX_STOP  = 3'b110
    } srbp_rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b011,
        TX_PAR   = 3'b010,
        TX_STOP  = 3'b110,
        TX_SPI   = 3'b100
    } srbp_tx_state_t;

    // number of data bits for a character-size code
    function automatic logic [3:0] srbp_data_bits(input logic [2:0] sel);
        case (sel)
            3'h0:      srbp_data_bits = 4'h5;
            3'h1:      srbp_data_bits = 4'h6;
            3'h2:      srbp_data_bits = 4'h7;
            SIZE_NINE: srbp_data_bits = 4'h9;
            default:   srbp_data_bits = 4'h8;
        endcase
    endfunction
endpackage

// >>> inc/srbp_stream_if.sv
// valid/ready word stream between the receive logic and its queue
`timescale 1ns/100ps
interface srbp_stream_if #(parameter int W = 12);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> src/srbp_baud_gen.sv
// baud tick generator: one tick every divisor+1 clocks
`timescale 1ns/100ps
module srbp_baud_gen
    import srbp_pkg::*;
(
    input  wire logic             sys_clk_i, // system clock
    input  wire logic             rst_b_i,   // sync reset, active low
    input  wire logic [DIV_W-1:0] div_i,     // baud divisor
    output logic                  tick_o     // one-cycle rate tick
);
    logic [DIV_W-1:0] cnt;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cnt    <= DIV_RST;
            tick_o <= 1'b0;
        end else if (cnt == '0) begin
            cnt    <= div_i; // divisor zero ticks every clock
            tick_o <= 1'b1;
        end else begin
            cnt    <= cnt - 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule // srbp_baud_gen

// >>> src/srbp_pair_fifo.sv
// shift-style queue; the head entry always sits in entry 0
`timescale 1ns/100ps
module srbp_pair_fifo
    import srbp_pkg::*;
#(
    parameter int W     = ENTRY_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic sys_clk_i, // system clock
    input  wire logic rst_b_i,   // sync reset, active low
    srbp_stream_if.snk wr,       // filling side
    srbp_stream_if.src rd        // draining side
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0]  mem [DEPTH];
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          push;
    logic          pop;
    logic [CW-1:0] wr_idx;
    logic          nonempty;

    assign wr.ready   = (count != CW'(DEPTH));
    assign push       = wr.valid && wr.ready;
    assign pop        = rd.ready && nonempty;
    assign wr_idx     = pop ? count - 1'b1 : count;
    assign next_count = count + CW'(push) - CW'(pop);
    assign rd.valid   = nonempty;
    assign rd.data    = mem[0];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            count    <= '0;
            nonempty <= 1'b0;
        end else begin
            count    <= next_count;
            nonempty <= (next_count != '0);
        end
    end

    // a pop frees its slot for a push only from the next cycle; write ready ignores a pop
    for (genvar g = 0; g < DEPTH; g++) begin : g_slot
        always_ff @(posedge sys_clk_i) begin
            if (!rst_b_i) begin
                mem[g] <= '0;
            end else if (push && wr_idx == CW'(g)) begin
                mem[g] <= wr.data;
            end else if (pop) begin
                if (g < DEPTH - 1) begin
                    mem[g] <= mem[(g + 1) % DEPTH];
                end else begin
                    mem[g] <= '0;
                end
            end
        end
    end
endmodule // srbp_pair_fifo

// >>> src/srbp_top.sv
// serial transceiver: receive queue, status flags, transmitter, spi master
//
// Summary of operation
// - Transmit-complete rises once shifter and data buffer are both empty.
// - Receive-complete is high exactly while the queue holds unread data.
// - Frames shorter than eight bits read back with zero upper bits.
// - Size code seven selects nine-bit characters; ninth bit read separately.
// - Each queue entry keeps ninth bit and error flags; reads pop it.
// - Reading data frees the slot for a new character one cycle after the read.
// - Divisor zero is fastest; double speed halves bit time.
// - In spi mode a data write starts an exchange; result sets receive-complete.
// - In spi mode exchange results carry zero frame, overrun and parity errors; entries queued before the switch keep theirs.
`timescale 1ns/100ps
module srbp_top
    import srbp_pkg::*;
(
    input  wire logic             sys_clk_i,          // 100 MHz clock
    input  wire logic             rst_b_i,            // sync reset, low
    input  wire logic             rx_pin_i,           // serial in / miso
    output logic                  tx_pin_o,           // serial out / mosi
    output logic                  sck_o,              // spi clock
    input  wire logic             rx_en_i,            // receiver enable
    input  wire logic             tx_en_i,            // transmitter enable
    input  wire logic             spi_master_mode_i,  // spi master mode
    input  wire logic [2:0]       char_size_sel_i,    // character size
    input  wire logic [1:0]       parity_mode_i,      // 2 even, 3 odd
    input  wire logic             stop2_i,            // two stop bits
    input  wire logic [DIV_W-1:0] baud_divisor_i,     // baud divisor
    input  wire logic             double_speed_sel_i, // double speed
    input  wire logic             data_wr_i,          // data write strobe
    input  wire logic [7:0]       data_wdata_i,       // byte to send
    input  wire logic             tx_ninth_bit_i,     // ninth bit to send
    input  wire logic             data_rd_i,          // data read strobe
    input  wire logic             tx_cmp_clr_i,       // clear tx complete
    output logic [7:0]            data_rdata_o,       // queue head data
    output logic                  rx_ninth_bit_o,     // head ninth bit
    output logic                  frame_err_flag_o,   // head frame error
    output logic                  overrun_flag_o,     // head overrun
    output logic                  parity_err_flag_o,  // head parity error
    output logic                  rx_complete_flag_o, // unread data
    output logic                  tx_complete_flag_o, // transmitter idle
    output logic                  data_empty_flag_o   // data buffer free
);
    srbp_stream_if #(.W(ENTRY_W)) q_in ();
    srbp_stream_if #(.W(ENTRY_W)) q_out ();

    logic           tick;
    logic [4:0]     os;
    logic [3:0]     nbits;
    logic           par_on;
    logic           par_odd;
    logic           rx_s1;
    logic           rx_s2;
    logic           rx_s3;
    logic           rx_line;
    srbp_rx_state_t rx_state;
    logic [4:0]     rx_os;
    logic [3:0]     rx_bits;
    logic [8:0]     rx_sh;
    logic [8:0]     rx_aligned;
    logic           rx_par;
    logic           rx_pe;
    logic           rx_done;
    logic [ENTRY_W-1:0] rx_word;
    srbp_tx_state_t tx_state;
    logic [4:0]     tx_os;
    logic [3:0]     tx_bits;
    logic [8:0]     tx_sh;
    logic           tx_par;
    logic           tx_stop2nd;
    logic [8:0]     tx_buf;
    logic           tx_done;
    logic [3:0]     spi_ph;
    logic [7:0]     spi_in;
    logic           spi_done;
    logic [7:0]     spi_byte;
    logic           psh_valid;
    logic [ENTRY_W-1:0] psh_data;
    logic           dor_pend;

    assign os         = double_speed_sel_i ? OS_DOUBLE : OS_NORMAL;
    assign nbits      = srbp_data_bits(char_size_sel_i);
    assign par_on     = parity_mode_i[1];
    assign par_odd    = (parity_mode_i == PAR_ODD);
    assign rx_aligned = 9'(rx_sh >> (4'h9 - nbits));

    srbp_baud_gen u_baud (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .div_i     (baud_divisor_i),
        .tick_o    (tick)
    );

    srbp_pair_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_queue (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .wr        (q_in.snk),
        .rd        (q_out.src)
    );

    // head entry drives the read-side outputs directly
    assign q_in.valid         = psh_valid;
    assign q_in.data          = psh_data;
    assign q_out.ready        = data_rd_i; // read pops the head
    assign data_rdata_o       = q_out.data[7:0];
    assign rx_ninth_bit_o     = q_out.data[ENT_NINTH];
    assign frame_err_flag_o   = q_out.data[ENT_FE];
    assign overrun_flag_o     = q_out.data[ENT_DOR];
    assign parity_err_flag_o  = q_out.data[ENT_PE];
    assign rx_complete_flag_o = q_out.valid;

    // pin synchroniser: a level counts once stages two and three agree
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rx_s1   <= LINE_IDLE;
            rx_s2   <= LINE_IDLE;
            rx_s3   <= LINE_IDLE;
            rx_line <= LINE_IDLE;
        end else begin
            rx_s1 <= rx_pin_i;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) begin
                rx_line <= rx_s3;
            end
        end
    end

    // asynchronous receiver, sampled mid-bit
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rx_state <= RX_IDLE;
            rx_os    <= '0;
            rx_bits  <= '0;
            rx_sh    <= '0;
            rx_par   <= 1'b0;
            rx_pe    <= 1'b0;
            rx_done  <= 1'b0;
            rx_word  <= '0;
        end else begin
            rx_done <= 1'b0;
            if (!rx_en_i || spi_master_mode_i) begin
                rx_state <= RX_IDLE;
            end else begin
                unique case (rx_state)
                    RX_IDLE: begin
                        rx_os <= '0;
                        if (!rx_line) begin
                            rx_state <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (tick) begin
                            rx_os <= rx_os + 1'b1;
                            if (rx_os == (os >> 1) - 1'b1) begin
                                rx_os   <= '0;
                                rx_bits <= '0;
                                rx_par  <= 1'b0;
                                rx_pe   <= 1'b0;
                                rx_state <= rx_line ? RX_IDLE : RX_DATA;
                            end
                        end
                    end
                    RX_DATA: begin
                        if (tick) begin
                            rx_os <= rx_os + 1'b1;
                            if (rx_os == os - 1'b1) begin
                                rx_os   <= '0;
                                rx_sh   <= {rx_line, rx_sh[8:1]};
                                rx_par  <= rx_par ^ rx_line;
                                rx_bits <= rx_bits + 1'b1;
                                if (rx_bits == nbits - 1'b1) begin
                                    rx_state <= par_on ? RX_PAR : RX_STOP;
                                end
                            end
                        end
                    end
                    RX_PAR: begin
                        if (tick) begin
                            rx_os <= rx_os + 1'b1;
                            if (rx_os == os - 1'b1) begin
                                rx_os    <= '0;
                                rx_pe    <= rx_line ^ rx_par ^ par_odd;
                                rx_state <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (tick) begin
                            rx_os <= rx_os + 1'b1;
                            if (rx_os == os - 1'b1) begin
                                rx_done  <= 1'b1;
                                rx_word  <= {
                                    (nbits == 4'h9) & rx_aligned[8],
                                    !rx_line, 1'b0, rx_pe,
                                    rx_aligned[7:0]};
                                rx_state <= RX_IDLE;
                            end
                        end
                    end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // push stage: a character is lost only when both slots are taken
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            psh_valid <= 1'b0;
            psh_data  <= '0;
            dor_pend  <= 1'b0;
        end else begin
            if (psh_valid && q_in.ready) begin
                psh_valid <= 1'b0;
            end
            if (rx_done || spi_done) begin
                if (!q_in.ready) begin
                    dor_pend <= !spi_done;
                end else begin
                    psh_valid <= 1'b1;
                    dor_pend  <= 1'b0;
                    if (spi_done) begin
                        psh_data <= {4'h0, spi_byte};
                    end else begin
                        psh_data <= rx_word;
                        psh_data[ENT_DOR] <= dor_pend;
                    end
                end
            end
        end
    end

    // transmit data buffer
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tx_buf            <= '0;
            data_empty_flag_o <= 1'b1;
        end else if (data_wr_i) begin
            tx_buf            <= {tx_ninth_bit_i, data_wdata_i};
            data_empty_flag_o <= 1'b0;
        end else if (tx_state == TX_IDLE && tx_en_i) begin
            data_empty_flag_o <= 1'b1;
        end
    end

    // transmitter and spi master shifter
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tx_state   <= TX_IDLE;
            tx_os      <= '0;
            tx_bits    <= '0;
            tx_sh      <= '0;
            tx_par     <= 1'b0;
            tx_stop2nd <= 1'b0;
            tx_pin_o   <= LINE_IDLE;
            sck_o      <= 1'b0;
            tx_done    <= 1'b0;
            spi_ph     <= '0;
            spi_in     <= '0;
            spi_done   <= 1'b0;
            spi_byte   <= '0;
        end else begin
            tx_done  <= 1'b0;
            spi_done <= 1'b0;
            unique case (tx_state)
                TX_IDLE: begin
                    tx_os      <= '0;
                    tx_bits    <= '0;
                    tx_par     <= 1'b0;
                    tx_stop2nd <= 1'b0;
                    spi_ph     <= '0;
                    sck_o      <= 1'b0;
                    if (tx_en_i && !data_empty_flag_o) begin
                        tx_sh <= tx_buf;
                        if (spi_master_mode_i) begin
                            tx_pin_o <= tx_buf[7];
                            tx_state <= TX_SPI;
                        end else begin
                            tx_pin_o <= 1'b0;
                            tx_state <= TX_START;
                        end
                    end
                end
                TX_START: begin
                    if (tick) begin
                        tx_os <= tx_os + 1'b1;
                        if (tx_os == os - 1'b1) begin
                            tx_os    <= '0;
                            tx_pin_o <= tx_sh[0];
                            tx_state <= TX_DATA;
                        end
                    end
                end
                TX_DATA: begin
                    if (tick) begin
                        tx_os <= tx_os + 1'b1;
                        if (tx_os == os - 1'b1) begin
                            tx_os   <= '0;
                            tx_sh   <= tx_sh >> 1;
                            tx_par  <= tx_par ^ tx_sh[0];
                            tx_bits <= tx_bits + 1'b1;
                            tx_pin_o <= tx_sh[1];
                            if (tx_bits == nbits - 1'b1) begin
                                tx_pin_o <= par_on ?
                                    tx_par ^ tx_sh[0] ^ par_odd : LINE_IDLE;
                                tx_state <= par_on ? TX_PAR : TX_STOP;
                            end
                        end
                    end
                end
                TX_PAR: begin
                    if (tick) begin
                        tx_os <= tx_os + 1'b1;
                        if (tx_os == os - 1'b1) begin
                            tx_os    <= '0;
                            tx_pin_o <= LINE_IDLE;
                            tx_state <= TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    if (tick) begin
                        tx_os <= tx_os + 1'b1;
                        if (tx_os == os - 1'b1) begin
                            tx_os <= '0;
                            if (stop2_i && !tx_stop2nd) begin
                                tx_stop2nd <= 1'b1;
                            end else begin
                                tx_done  <= 1'b1;
                                tx_state <= TX_IDLE;
                            end
                        end
                    end
                end
                TX_SPI: begin
                    if (tick && tx_os == '0) begin
                        tx_os <= 5'h01; // mosi setup half phase
                    end else if (tick) begin
                        spi_ph <= spi_ph + 1'b1;
                        if (!spi_ph[0]) begin
                            sck_o  <= 1'b1;
                            spi_in <= {spi_in[6:0], rx_line};
                        end else begin
                            sck_o    <= 1'b0;
                            tx_sh    <= {tx_sh[8], tx_sh[6:0], 1'b0};
                            tx_pin_o <= tx_sh[6];
                            if (spi_ph == SPI_LAST_PH) begin
                                tx_pin_o <= LINE_IDLE;
                                spi_done <= 1'b1;
                                spi_byte <= spi_in;
                                tx_done  <= 1'b1;
                                tx_state <= TX_IDLE;
                            end
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // transmit complete: a set in the clearing cycle wins
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tx_complete_flag_o <= 1'b0;
        end else if (tx_done && data_empty_flag_o && !data_wr_i) begin
            tx_complete_flag_o <= 1'b1;
        end else if (tx_cmp_clr_i) begin
            tx_complete_flag_o <= 1'b0;
        end
    end
endmodule // srbp_top

// >>> test/srbp_chk.sv
// concurrent checks on the serial receive path top ports
`timescale 1ns/100ps
module srbp_chk
    import srbp_pkg::*;
(
    input wire logic       sys_clk_i,          // clock
    input wire logic       rst_b_i,            // reset
    input wire logic       spi_master_mode_i,  // spi mode
    input wire logic [2:0] char_size_sel_i,    // size
    input wire logic       data_wr_i,          // write
    input wire logic       data_rd_i,          // read
    input wire logic       tx_cmp_clr_i,       // clear
    input wire logic [7:0] data_rdata_o,       // head data
    input wire logic       rx_ninth_bit_o,     // ninth bit
    input wire logic       frame_err_flag_o,   // frame err
    input wire logic       overrun_flag_o,     // overrun
    input wire logic       parity_err_flag_o,  // parity err
    input wire logic       rx_complete_flag_o, // unread
    input wire logic       tx_complete_flag_o, // tx idle
    input wire logic       data_empty_flag_o   // buffer free
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_empty_reads_zero: assert property (
        !rx_complete_flag_o |-> {data_rdata_o, rx_ninth_bit_o,
        frame_err_flag_o, overrun_flag_o, parity_err_flag_o} == 12'h000)
        else $error("head not zero while queue empty");
    a_fall_on_pop: assert property (
        $fell(rx_complete_flag_o) |-> $past(data_rd_i))
        else $error("receive flag fell without a read");
    a_short_upper_zero: assert property (
        rx_complete_flag_o && char_size_sel_i == 3'h0
        |-> data_rdata_o[7:5] == 3'h0)
        else $error("upper bits set in short frame");
    a_ninth_only_nine: assert property (
        rx_complete_flag_o && char_size_sel_i != SIZE_NINE
        |-> !rx_ninth_bit_o)
        else $error("ninth bit set outside nine bit mode");
    a_spi_no_errors: assert property (
        spi_master_mode_i && $past(spi_master_mode_i)
        && $rose(rx_complete_flag_o)
        |-> !(frame_err_flag_o || overrun_flag_o || parity_err_flag_o))
        else $error("error flag in spi mode");
    a_write_takes_buf: assert property (
        data_wr_i && data_empty_flag_o |=> !data_empty_flag_o)
        else $error("buffer still empty after write");
    a_txc_when_idle: assert property (
        $rose(tx_complete_flag_o) |-> data_empty_flag_o)
        else $error("tx complete with data pending");
    a_txc_sticky: assert property (
        tx_complete_flag_o && !tx_cmp_clr_i |=> tx_complete_flag_o)
        else $error("tx complete dropped without clear");
    c_overrun: cover property ($rose(overrun_flag_o));
    c_parity: cover property (rx_complete_flag_o && parity_err_flag_o);
    c_spi: cover property (spi_master_mode_i && $rose(rx_complete_flag_o));
endmodule // srbp_chk
bind srbp_top srbp_chk srbp_chk_inst (.*);

// >>> test/srbp_remote.sv
// remote serial device: sends frames, echoes mosi in spi mode
`timescale 1ns/100ps
module srbp_remote (
    input  wire logic sys_clk_i, // clock
    input  wire logic spi_i,     // spi mode
    input  wire logic mosi_i,    // from device
    output logic      line_o     // to device
);
    logic uart_line = 1'b1;
    // the spi slave returns what it is sent
    assign line_o = spi_i ? mosi_i : uart_line;
    task automatic put(input logic b, input int bt);
        uart_line <= b;
        repeat (bt) @(posedge sys_clk_i);
    endtask
    // lsb first frame; bad_par and bad_stop corrupt it on purpose
    task automatic send(input logic [8:0] d, input int nb, input int par,
                        input logic bad_par, input logic bad_stop,
                        input int bt);
        logic p;
        p = ^(d & ((9'h1 << nb) - 9'h1)) ^ (par == 3) ^ bad_par;
        @(posedge sys_clk_i);
        put(1'b0, bt);
        for (int i = 0; i < nb; i++)
            put(d[i], bt);
        if (par >= 2)
            put(p, bt);
        put(!bad_stop, bt);
        put(1'b1, bt);
    endtask
endmodule // srbp_remote

// >>> test/test_serial_receive_buffer_path.sv
// self-checking bench for the serial receive path
`timescale 1ns/100ps
module test_serial_receive_buffer_path
    import srbp_pkg::*;
;
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, rx_en_i = 1'b1, tx_en_i = 1'b1;
    logic stop2_i = 1'b0, spi_master_mode_i = 1'b0, double_speed_sel_i = 1'b0;
    logic data_wr_i = 1'b0, data_rd_i = 1'b0, tx_cmp_clr_i = 1'b0;
    logic tx_ninth_bit_i = 1'b0, rx_pin_i, tx_pin_o, sck_o, rx_ninth_bit_o;
    logic frame_err_flag_o, overrun_flag_o, parity_err_flag_o;
    logic rx_complete_flag_o, tx_complete_flag_o, data_empty_flag_o;
    logic [2:0]       char_size_sel_i = 3'h3;
    logic [1:0]       parity_mode_i = 2'h0;
    logic [DIV_W-1:0] baud_divisor_i = 12'h000;
    logic [7:0]       data_wdata_i = 8'h00, data_rdata_o;
    logic [8:0]       d;
    int               mismatches = 0, tests_run = 0, bt, nb, pm;
    srbp_top srbp_top_inst (.*);
    srbp_remote srbp_remote_inst (.sys_clk_i(sys_clk_i),
        .spi_i(spi_master_mode_i), .mosi_i(tx_pin_o), .line_o(rx_pin_i));
    always #5 sys_clk_i = ~sys_clk_i;
    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    // 0 receive, 1 transmit done, 2 buffer free
    task automatic wait_on(input int w);
        int n;
        for (n = 0; n < 5000; n++) begin
            @(posedge sys_clk_i);
            #1;
            if ((w == 0 ? rx_complete_flag_o : w == 1 ? tx_complete_flag_o
                : data_empty_flag_o) === 1'b1)
                break;
        end
        if (n == 5000) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task automatic setup(input logic [2:0] s, input logic [1:0] p,
                         input logic ds, input logic [DIV_W-1:0] dv);
        @(posedge sys_clk_i);
        char_size_sel_i <= s;
        parity_mode_i <= p;
        double_speed_sel_i <= ds;
        baud_divisor_i <= dv;
        bt = (ds ? 8 : 16) * (int'(dv) + 1);
        pm = p;
        nb = s == 3'h7 ? 9 : s < 3'h4 ? int'(s) + 5 : 8;
    endtask
    // compare the head entry, then pop it
    task automatic head(input logic [8:0] v, input logic [2:0] err);
        wait_on(0);
        check({rx_ninth_bit_o, data_rdata_o}, v & ((9'h1 << nb) - 9'h1));
        check({6'h0, frame_err_flag_o, overrun_flag_o, parity_err_flag_o},
              {6'h0, err});
        @(posedge sys_clk_i);
        data_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        data_rd_i <= 1'b0;
    endtask
    task automatic rx(input logic [8:0] v, input logic bp, input logic bs);
        srbp_remote_inst.send(v, nb, pm, bp, bs, bt);
        head(v, {bs, 1'b0, bp});
    endtask
    task automatic wr(input logic [7:0] v);
        wait_on(2);
        @(posedge sys_clk_i);
        tx_cmp_clr_i <= 1'b1;
        @(posedge sys_clk_i);
        tx_cmp_clr_i <= 1'b0;
        data_wr_i <= 1'b1;
        data_wdata_i <= v;
        tx_ninth_bit_i <= 1'($urandom);
        @(posedge sys_clk_i);
        data_wr_i <= 1'b0;
    endtask
    initial begin
        logic [2:0] sz [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        logic [8:0] q [3];
        d = 9'($urandom(72));
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        for (int k = 0; k < 10; k++) begin
            setup(sz[k % 5], k < 5 ? 2'h0 : 2'(2 + k % 2), k[0], 12'(k % 4));
            rx(9'($urandom), 1'b0, 1'b0);
        end
        @(posedge sys_clk_i);
        #1;
        check({8'h00, rx_complete_flag_o}, 9'h000);
        $display("formats done");
        setup(3'h3, 2'h2, 1'b0, 12'h001);
        rx(9'($urandom), 1'b1, 1'b0);
        rx(9'($urandom), 1'b0, 1'b1);
        $display("errors done");
        setup(3'h3, 2'h0, 1'b0, 12'h000);
        for (int k = 0; k < 3; k++) begin
            q[k] = 9'($urandom);
            srbp_remote_inst.send(q[k], nb, 0, 1'b0, 1'b0, bt);
        end
        head(q[0], 3'h0);
        head(q[1], 3'h0);
        d = 9'($urandom);
        srbp_remote_inst.send(d, nb, 0, 1'b0, 1'b0, bt);
        head(d, 3'h2);
        $display("overrun done");
        wr(8'($urandom));
        repeat (2) @(posedge sys_clk_i);
        #1;
        check({8'h00, tx_pin_o}, 9'h000);
        wait_on(1);
        check({8'h00, tx_complete_flag_o}, 9'h001);
        $display("transmit done");
        setup(3'h3, 2'h0, 1'b0, 12'h004);
        spi_master_mode_i <= 1'b1;
        d = 9'($urandom);
        wr(d[7:0]);
        head({1'b0, d[7:0]}, 3'h0);
        wait_on(1);
        check({7'h00, sck_o, tx_complete_flag_o}, 9'h001);
        $display("spi done");
        report_and_stop();
    end
endmodule // test_serial_receive_buffer_path
